// [tb/scd_host_model.sv]
`timescale 1ns/1ns
// ----------------------------------------
// Serial host, mode 0,0, 320 ns clock
// ----------------------------------------
module scd_host_model
(
   // Pins toward the device
   output logic      sckPin,
   output logic      csPin_b,
   output logic      siPin,
   input  wire logic soOut
);
   // Idle: clock low, deselected
   initial
   begin
      sckPin = 1'b0;
      csPin_b = 1'b1;
      siPin = 1'b0;
   end

   // Select, with one and a half periods before the first edge
   task automatic sel();
      csPin_b = 1'b0;
      #320;
   endtask : sel

   // MSB first; SO sampled at the rising edge, after the device drove it
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--)
      begin
         siPin = tx[i];
         #160 sckPin = 1'b1;
         rx[i] = soOut;
         #160 sckPin = 1'b0;
      end
   endtask : xfer

   // End of frame; idle long enough for the flag clear to land
   task automatic desel();
      #160 csPin_b = 1'b1;
      siPin = ~siPin; // Stale data never left on the line
      #640;
   endtask : desel
endmodule : scd_host_model

// [tb/scd_spi_decoder_assertions.sv]
`timescale 1ns/1ns
// ----------------------------------------
// Port checker for the command decoder
// ----------------------------------------
module scd_spi_checker
(
   // Clock, reset and select pin
   input wire logic       ref_clk,
   input wire logic       rst_b,
   input wire logic       csPin_b,
   // Decoder outputs
   input wire logic       soOut,
   input wire logic       soOe,
   input wire logic [7:0] regAddr,
   input wire logic       regWrEn,
   input wire logic [7:0] regWrMask,
   input wire logic       softResetReq,
   input wire logic [2:0] txReqSet,
   input wire logic [1:0] rxFlagClr
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   // Addresses that accept a masked update; all others must see a full mask
   wire logic bitModOk = (regAddr inside {8'h0C, 8'h0D, [8'h28:8'h2D], 8'h30, 8'h40, 8'h50,
                          8'h60, 8'h70}) || (regAddr[3:1] == 3'h7);

   a_wr_one_cycle: assert property (regWrEn |=> !regWrEn)
      else $error("write strobe held too long");
   a_rts_one_pulse: assert property (|txReqSet |=> txReqSet == 3'h0)
      else $error("send request held too long");
   a_reset_one_pulse: assert property (softResetReq |=> !softResetReq)
      else $error("reset request held too long");
   a_so_idle_low: assert property (!soOe |-> !soOut)
      else $error("serial out not idle");
   a_oe_needs_select: assert property ($rose(soOe) |-> !csPin_b)
      else $error("output enabled while deselected");
   a_clear_at_deselect: assert property (|rxFlagClr |-> csPin_b)
      else $error("flag clear before deselect");
   a_ptr_held_write: assert property (regWrEn |-> $stable(regAddr))
      else $error("pointer moved during write");
   a_mask_forced_full: assert property (regWrEn && !bitModOk |-> regWrMask == 8'hFF)
      else $error("partial mask on plain register");

   // Main scenarios reached
   c_masked_write: cover property (regWrEn && regWrMask != 8'hFF);
   c_send_request: cover property (|txReqSet);
   c_flag_clear: cover property (|rxFlagClr);
endmodule : scd_spi_checker

bind scd_spi_decoder scd_spi_checker chk_u (.ref_clk, .rst_b, .csPin_b, .soOut, .soOe,
   .regAddr, .regWrEn, .regWrMask, .softResetReq, .txReqSet, .rxFlagClr);

// [tb/tb.sv]
`timescale 1ns/1ns
module tb;
   logic       ref_clk, rst_b, sckPin, csPin_b, siPin, soOut, soOe, regWrEn, rstSeen;
   logic       softResetReq;
   logic [7:0] regAddr, regWrData, regWrMask, quickStatus, rx;
   logic [7:0] regs [256];
   logic [2:0] txReqSet, rx0FilterHit, rx1FilterHit, txSeen;
   logic [1:0] rxFlagClr, rxFullFlag, rxExtId, rxRemote, clrSeen;
   int         mismatches, comparisons;

   // ----------------------------------------
   // Clock, device and host
   // ----------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   scd_spi_decoder dut_u (.ref_clk, .rst_b, .sckPin, .csPin_b, .siPin, .soOut, .soOe,
      .regAddr, .regWrEn, .regWrData, .regWrMask, .regRdData(regs[regAddr]), .softResetReq,
      .txReqSet, .rxFlagClr, .quickStatus, .rxFullFlag, .rxExtId, .rxRemote, .rx0FilterHit,
      .rx1FilterHit);
   scd_host_model host_u (.sckPin, .csPin_b, .siPin, .soOut);

   // Register file stand-in and event catchers
   always @(posedge ref_clk)
   begin
      if (regWrEn)
         regs[regAddr] <= (regs[regAddr] & ~regWrMask) | (regWrData & regWrMask);
      txSeen <= txSeen | txReqSet;
      clrSeen <= clrSeen | rxFlagClr;
      rstSeen <= rstSeen | softResetReq;
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic put(input logic [7:0] b);
      host_u.xfer(b, 8, rx);
   endtask : put

   task automatic frame2(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d);
      txSeen = 3'h0;
      clrSeen = 2'h0;
      rstSeen = 1'b0;
      host_u.sel();
      put(op);
      put(a);
      put(d);
      host_u.desel();
   endtask : frame2

   // Two answer bytes after one opcode, both must match
   task automatic poll(input logic [7:0] op, input logic [7:0] exp);
      host_u.sel();
      put(op);
      put(8'h00);
      chk(rx, exp);
      chk({7'h00, soOe}, {7'h00, op != 8'hFF});
      put(8'h00);
      chk(rx, exp);
      host_u.desel();
   endtask : poll

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic test_misc();
      rstSeen = 1'b0;
      host_u.sel();
      put(8'hC0);
      host_u.desel();
      chk({7'h00, rstSeen}, 8'h01);
      poll(8'hFF, 8'h00);
      frame2(8'h43, 8'h77, 8'h00);
      chk(regs[8'h46], 8'h77);
      $display("test_misc done");
   endtask : test_misc

   task automatic test_write_read();
      host_u.sel();
      put(8'h02);
      put(8'h31);
      put(8'hA5);
      put(8'h5A);
      host_u.xfer(8'hFF, 4, rx); // Cut short on purpose
      host_u.desel();
      chk(regs[8'h31], 8'hA5);
      chk(regs[8'h32], 8'h5A);
      chk(regs[8'h33], 8'h00);
      host_u.sel();
      put(8'h03);
      put(8'h31);
      put(8'h00);
      chk(rx, 8'hA5);
      put(8'h00);
      chk(rx, 8'h5A);
      host_u.desel();
      $display("test_write_read done");
   endtask : test_write_read

   task automatic test_bitmod();
      frame2(8'h02, 8'h2B, 8'hA0);
      host_u.sel();
      put(8'h05);
      frame2(8'h2B, 8'h0F, 8'h35); // Address, mask, data in the open frame
      chk(regs[8'h2B], 8'hA5);
      host_u.sel();
      put(8'h05);
      frame2(8'h31, 8'h0F, 8'h3C);
      chk(regs[8'h31], 8'h3C);
      $display("test_bitmod done");
   endtask : test_bitmod

   task automatic test_rts();
      for (int n = 0; n < 8; n++)
      begin
         frame2(8'h80 | 8'(n), 8'h00, 8'h00);
         chk({5'h00, txSeen}, 8'(n));
      end
      $display("test_rts done");
   endtask : test_rts

   task automatic test_rxb();
      logic [7:0] ea;
      for (int k = 0; k < 4; k++)
      begin
         ea = {4'h6 + 4'(k[1]), k[0] ? 4'h6 : 4'h1};
         regs[ea] = ~ea;
         regs[ea + 8'h01] = ea;
         clrSeen = 2'h0;
         host_u.sel();
         put(8'h90 | 8'(k << 1));
         put(8'h00);
         chk(rx, ~ea);
         put(8'h00);
         chk(rx, ea);
         host_u.desel();
         chk({6'h00, clrSeen}, 8'h01 << k[1]);
      end
      $display("test_rxb done");
   endtask : test_rxb

   task automatic test_status();
      poll(8'hA0, 8'h5A);
      poll(8'hB0, 8'hD5);
      rxFullFlag = 2'h2;
      poll(8'hB0, 8'h8E);
      $display("test_status done");
   endtask : test_status

   // ----------------------------------------
   // Sequence, watchdog and verdict
   // ----------------------------------------
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict

   initial
   begin
      #3000000;
      mismatches++;
      print_verdict();
   end

   initial
   begin
      foreach (regs[i]) regs[i] = 8'h00;
      {rst_b, txSeen, clrSeen, rstSeen} = 7'h00;
      quickStatus = 8'h5A;
      {rxFullFlag, rxExtId, rxRemote} = 6'h36;
      rx0FilterHit = 3'h5;
      rx1FilterHit = 3'h6;
      repeat (4) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge ref_clk);
      test_misc();
      test_write_read();
      test_bitmod();
      test_rts();
      test_rxb();
      test_status();
      print_verdict();
   end
endmodule : tb

// [verilog/scd_defines.svh]
// Summary of operation
// - Reset opcode requests full device reset
// - Read opcode, address, then register data out
// - Pointer advances after each byte read
// - Receive buffer read sets pointer, no address
// - Frame end clears flag of buffer read
// - Write opcode, address, data to successive registers
// - Commit byte on its last rising edge
// - Partial write byte discarded at frame end
// - Load transmit buffer sets write pointer directly
// - Request-to-send sets selected transmit requests
// - Request-to-send with no selection does nothing
// - Read status byte repeats while clocked
// - Receive status byte repeats while clocked
// - Status top bits show receive-full flags
// - Bits four, three give frame type
// - Bits two to zero give filter hit
// - Buffer zero owns low bits when both full
// - Bit modify: opcode, address, mask, data
// - Only masked bits take new data
// - Unmodifiable register forces mask to all ones
// - Sample rising, drive falling, select low
`ifndef SCD_DEFINES_SVH
`define SCD_DEFINES_SVH

// ------------------------------------------------------------
// Opcodes and opcode masks
// ------------------------------------------------------------
`define SCD_OP_RESET     8'hC0
`define SCD_OP_READ      8'h03
`define SCD_OP_WRITE     8'h02
`define SCD_OP_BITMOD    8'h05
`define SCD_OP_RDSTAT    8'hA0
`define SCD_OP_RXSTAT    8'hB0
`define SCD_OP_RXB       8'h90
`define SCD_OP_RXB_MASK  8'hF9
`define SCD_OP_LDTX      8'h40
`define SCD_OP_RTS       8'h80
`define SCD_OP_SEL3_MASK 8'hF8

// ------------------------------------------------------------
// Buffer address layout
// ------------------------------------------------------------
`define SCD_TXB_HI       4'h3
`define SCD_RXB_HI       4'h6
`define SCD_ID_LO        4'h1
`define SCD_DATA_LO      4'h6
`define SCD_LDTX_MAX     3'h5
`define SCD_CTRL_LO      4'h0
`define SCD_STAT_LO      4'hE
`define SCD_CCTRL_LO     4'hF
`define SCD_BFP_ADDR     8'h0C
`define SCD_RTSCTL_ADDR  8'h0D
`define SCD_CNF3_ADDR    8'h28
`define SCD_FLAG_ADDR    8'h2C
`define SCD_EFLG_ADDR    8'h2D

// ------------------------------------------------------------
// Misc values
// ------------------------------------------------------------
`define SCD_MASK_ALL     8'hFF
`define SCD_BYTE_ZERO    8'h00
`define SCD_LAST_BIT     3'h7
`define SCD_FIRST_BIT    3'h0
`define SCD_PIN_RST      3'h2

`endif

// [verilog/scd_pkg.sv]
package scd_pkg;

   // Frame states, Gray along command -> address -> mask -> data
   typedef enum logic [2:0]
   {
      ST_CMD    = 3'h0,
      ST_ADDR   = 3'h1,
      ST_MASK   = 3'h3,
      ST_BMDATA = 3'h2,
      ST_WRITE  = 3'h6,
      ST_READ   = 3'h7,
      ST_STATUS = 3'h5,
      ST_IGNORE = 3'h4
   } scd_state_t;

   // Access kind carried from opcode to address byte
   typedef enum logic [1:0]
   {
      OP_READ   = 2'h0,
      OP_WRITE  = 2'h1,
      OP_BITMOD = 2'h3
   } scd_op_t;

   // Decoded opcode
   typedef enum logic [3:0]
   {
      CMD_NONE   = 4'h0,
      CMD_RESET  = 4'h1,
      CMD_READ   = 4'h2,
      CMD_WRITE  = 4'h3,
      CMD_BITMOD = 4'h4,
      CMD_RXB    = 4'h5,
      CMD_LDTX   = 4'h6,
      CMD_RTS    = 4'h7,
      CMD_RDSTAT = 4'h8,
      CMD_RXSTAT = 4'h9
   } scd_cmd_t;

endpackage : scd_pkg

// [verilog/scd_spi_decoder.sv]
`timescale 1ns/1ns
`include "scd_defines.svh"
module scd_spi_decoder
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst_b,
   // Serial pins
   input  wire logic       sckPin,
   input  wire logic       csPin_b,
   input  wire logic       siPin,
   output logic            soOut,
   output logic            soOe,
   // Register file port
   output logic [7:0]      regAddr,
   output logic            regWrEn,
   output logic [7:0]      regWrData,
   output logic [7:0]      regWrMask,
   input  wire logic [7:0] regRdData,
   // Controller events
   output logic            softResetReq,
   output logic [2:0]      txReqSet,
   output logic [1:0]      rxFlagClr,
   // Status sources
   input  wire logic [7:0] quickStatus,
   input  wire logic [1:0] rxFullFlag,
   input  wire logic [1:0] rxExtId,
   input  wire logic [1:0] rxRemote,
   input  wire logic [2:0] rx0FilterHit,
   input  wire logic [2:0] rx1FilterHit
);

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------

   // Opcode decode
   function automatic scd_pkg::scd_cmd_t decodeCmd(input logic [7:0] op);
      scd_pkg::scd_cmd_t cmd;
      cmd = scd_pkg::CMD_NONE;
      if (op == `SCD_OP_RESET)
         cmd = scd_pkg::CMD_RESET;
      else if (op == `SCD_OP_READ)
         cmd = scd_pkg::CMD_READ;
      else if (op == `SCD_OP_WRITE)
         cmd = scd_pkg::CMD_WRITE;
      else if (op == `SCD_OP_BITMOD)
         cmd = scd_pkg::CMD_BITMOD;
      else if (op == `SCD_OP_RDSTAT)
         cmd = scd_pkg::CMD_RDSTAT;
      else if (op == `SCD_OP_RXSTAT)
         cmd = scd_pkg::CMD_RXSTAT;
      else if ((op & `SCD_OP_RXB_MASK) == `SCD_OP_RXB)
         cmd = scd_pkg::CMD_RXB;
      else if ((op & `SCD_OP_SEL3_MASK) == `SCD_OP_LDTX && op[2:0] <= `SCD_LDTX_MAX)
         cmd = scd_pkg::CMD_LDTX;
      else if ((op & `SCD_OP_SEL3_MASK) == `SCD_OP_RTS)
         cmd = scd_pkg::CMD_RTS;
      return cmd;
   endfunction : decodeCmd

   // Start address of a buffer's identifier or data field
   function automatic logic [7:0] bufAddr(input logic [3:0] hiBase,
                                          input logic [1:0] idx,
                                          input logic       dataSel);
      logic [3:0] hi;
      hi = hiBase + {2'h0, idx};
      return {hi, (dataSel ? `SCD_DATA_LO : `SCD_ID_LO)};
   endfunction : bufAddr

   // Control and status registers that honour a mask
   function automatic logic bitModOk(input logic [7:0] a);
      logic ok;
      ok = (a == `SCD_BFP_ADDR) || (a == `SCD_RTSCTL_ADDR)
         || (a[3:0] == `SCD_STAT_LO) || (a[3:0] == `SCD_CCTRL_LO)
         || ((a >= `SCD_CNF3_ADDR) && (a <= `SCD_EFLG_ADDR))
         || ((a[3:0] == `SCD_CTRL_LO) && (a[7:4] >= `SCD_TXB_HI)
             && (a[7:4] <= `SCD_RXB_HI + 4'h1));
      return ok;
   endfunction : bitModOk

   // ------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ------------------------------------------------------------
   logic [2:0] pinSync;
   logic       sckSync;
   logic       csSync_b;
   logic       siSync;
   logic       sckPrev_q;
   logic       csPrev_q;
   logic       csLow;
   logic       sckRise;
   logic       sckFall;
   logic       csRise;

   scd_sync
   #(
      .WIDTH     (3),
      .STAGES    (2),
      .RESET_VAL (`SCD_PIN_RST)
   )
   uPinSync
   (
      .ref_clk (ref_clk),
      .rst_b   (rst_b),
      .asyncIn ({sckPin, csPin_b, siPin}),
      .syncOut (pinSync)
   );

   assign sckSync  = pinSync[2];
   assign csSync_b = pinSync[1];
   assign siSync   = pinSync[0];

   // Edge history; the link clock is oversampled, not used as a clock
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         sckPrev_q <= 1'b0;
         csPrev_q  <= 1'b1;
      end
      else
      begin
         sckPrev_q <= sckSync;
         csPrev_q  <= csSync_b;
      end
   end

   // Edges only count inside a frame
   assign csLow   = !csSync_b;
   assign sckRise = csLow && sckSync && !sckPrev_q;
   assign sckFall = csLow && !sckSync && sckPrev_q;
   assign csRise  = csSync_b && !csPrev_q;

   // ------------------------------------------------------------
   // Bit counter and input shifter
   // ------------------------------------------------------------
   logic [2:0]         bitCnt_q;
   logic [6:0]         rxShift_q;
   logic [7:0]         byteIn;
   logic               byteDone;
   scd_pkg::scd_cmd_t  cmd;

   assign byteIn   = {rxShift_q, siSync};
   assign byteDone = sckRise && (bitCnt_q == `SCD_LAST_BIT);
   assign cmd      = decodeCmd(byteIn);

   // Counter restarts with each frame, so a short byte never lands
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bitCnt_q  <= `SCD_FIRST_BIT;
         rxShift_q <= 7'h00;
      end
      else if (!csLow)
      begin
         bitCnt_q  <= `SCD_FIRST_BIT;
      end
      else if (sckRise)
      begin
         bitCnt_q  <= bitCnt_q + 3'h1;
         rxShift_q <= byteIn[6:0];
      end
   end

   // ------------------------------------------------------------
   // Frame state machine
   // ------------------------------------------------------------
   scd_pkg::scd_state_t state_q;
   scd_pkg::scd_op_t    op_q;
   logic [7:0]          mask_q;
   logic [7:0]          statByte_q;
   logic [7:0]          rxStatus;

   // Buffer zero wins the low field when both buffers are full
   always_comb
   begin
      rxStatus = {rxFullFlag[1], rxFullFlag[0], 1'b0, 5'h00};
      if (rxFullFlag[0])
         rxStatus[4:0] = {rxExtId[0], rxRemote[0], rx0FilterHit};
      else if (rxFullFlag[1])
         rxStatus[4:0] = {rxExtId[1], rxRemote[1], rx1FilterHit};
   end

   // Opcode, address and mask bytes steer the frame
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_q    <= scd_pkg::ST_CMD;
         op_q       <= scd_pkg::OP_READ;
         mask_q     <= `SCD_MASK_ALL;
         statByte_q <= `SCD_BYTE_ZERO;
      end
      else if (!csLow)
      begin
         state_q <= scd_pkg::ST_CMD;
      end
      else if (byteDone)
      begin
         unique case (state_q)
            scd_pkg::ST_CMD:
            begin
               unique case (cmd)
                  scd_pkg::CMD_READ:
                  begin
                     op_q    <= scd_pkg::OP_READ;
                     state_q <= scd_pkg::ST_ADDR;
                  end
                  scd_pkg::CMD_WRITE:
                  begin
                     op_q    <= scd_pkg::OP_WRITE;
                     state_q <= scd_pkg::ST_ADDR;
                  end
                  scd_pkg::CMD_BITMOD:
                  begin
                     op_q    <= scd_pkg::OP_BITMOD;
                     state_q <= scd_pkg::ST_ADDR;
                  end
                  scd_pkg::CMD_RXB:    state_q <= scd_pkg::ST_READ;
                  scd_pkg::CMD_LDTX:   state_q <= scd_pkg::ST_WRITE;
                  scd_pkg::CMD_RDSTAT:
                  begin
                     statByte_q <= quickStatus;
                     state_q    <= scd_pkg::ST_STATUS;
                  end
                  scd_pkg::CMD_RXSTAT:
                  begin
                     statByte_q <= rxStatus;
                     state_q    <= scd_pkg::ST_STATUS;
                  end
                  // Reset, send request and unknown codes swallow the rest
                  scd_pkg::CMD_NONE,
                  scd_pkg::CMD_RESET,
                  scd_pkg::CMD_RTS:    state_q <= scd_pkg::ST_IGNORE;
               endcase
            end
            scd_pkg::ST_ADDR:
            begin
               unique case (op_q)
                  scd_pkg::OP_READ:   state_q <= scd_pkg::ST_READ;
                  scd_pkg::OP_WRITE:  state_q <= scd_pkg::ST_WRITE;
                  scd_pkg::OP_BITMOD: state_q <= scd_pkg::ST_MASK;
                  default:            state_q <= scd_pkg::ST_IGNORE;
               endcase
            end
            scd_pkg::ST_MASK:
            begin
               mask_q  <= byteIn;
               state_q <= scd_pkg::ST_BMDATA;
            end
            scd_pkg::ST_BMDATA: state_q <= scd_pkg::ST_IGNORE;   // One data byte only
            scd_pkg::ST_WRITE,
            scd_pkg::ST_READ,
            scd_pkg::ST_STATUS,
            scd_pkg::ST_IGNORE: state_q <= state_q;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Address pointer
   // ------------------------------------------------------------
   logic [7:0] addr_q;
   logic       addrInc_q;

   // Write bumps the pointer one cycle late so the strobe sees the old value
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         addr_q    <= `SCD_BYTE_ZERO;
         addrInc_q <= 1'b0;
      end
      else
      begin
         addrInc_q <= byteDone && (state_q == scd_pkg::ST_WRITE);
         if (addrInc_q)
         begin
            addr_q <= addr_q + 8'h01;
         end
         else if (byteDone)
         begin
            if (state_q == scd_pkg::ST_ADDR)
               addr_q <= byteIn;
            else if (state_q == scd_pkg::ST_READ)
               addr_q <= addr_q + 8'h01;
            else if (state_q == scd_pkg::ST_CMD && cmd == scd_pkg::CMD_RXB)
               addr_q <= bufAddr(`SCD_RXB_HI, {1'b0, byteIn[2]}, byteIn[1]);
            else if (state_q == scd_pkg::ST_CMD && cmd == scd_pkg::CMD_LDTX)
               addr_q <= bufAddr(`SCD_TXB_HI, byteIn[2:1], byteIn[0]);
         end
      end
   end

   // ------------------------------------------------------------
   // Register write strobe
   // ------------------------------------------------------------
   logic       wrEn_q;
   logic [7:0] wrData_q;
   logic [7:0] wrMask_q;

   // Strobe fires only on a whole byte
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wrEn_q   <= 1'b0;
         wrData_q <= `SCD_BYTE_ZERO;
         wrMask_q <= `SCD_MASK_ALL;
      end
      else
      begin
         wrEn_q <= 1'b0;
         if (byteDone && state_q == scd_pkg::ST_WRITE)
         begin
            wrEn_q   <= 1'b1;
            wrData_q <= byteIn;
            wrMask_q <= `SCD_MASK_ALL;
         end
         else if (byteDone && state_q == scd_pkg::ST_BMDATA)
         begin
            wrEn_q   <= 1'b1;
            wrData_q <= byteIn;
            wrMask_q <= bitModOk(addr_q) ? mask_q : `SCD_MASK_ALL;
         end
      end
   end

   // ------------------------------------------------------------
   // Controller events
   // ------------------------------------------------------------
   logic       softRst_q;
   logic [2:0] tx_request_bit_q;
   logic [1:0] rxClr_q;
   logic       rxbRead_q;
   logic       rxbSel_q;

   // Flag clear waits for the frame end so the host can finish reading
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         softRst_q <= 1'b0;
         tx_request_bit_q   <= 3'h0;
         rxClr_q   <= 2'h0;
         rxbRead_q <= 1'b0;
         rxbSel_q  <= 1'b0;
      end
      else
      begin
         softRst_q <= byteDone && state_q == scd_pkg::ST_CMD
                      && cmd == scd_pkg::CMD_RESET;
         tx_request_bit_q   <= (byteDone && state_q == scd_pkg::ST_CMD
                      && cmd == scd_pkg::CMD_RTS) ? byteIn[2:0] : 3'h0;
         rxClr_q   <= 2'h0;
         if (csRise)
         begin
            rxbRead_q <= 1'b0;
            if (rxbRead_q)
               rxClr_q[rxbSel_q] <= 1'b1;
         end
         else if (byteDone && state_q == scd_pkg::ST_CMD && cmd == scd_pkg::CMD_RXB)
         begin
            rxbRead_q <= 1'b1;
            rxbSel_q  <= byteIn[2];
         end
      end
   end

   // ------------------------------------------------------------
   // Serial output
   // ------------------------------------------------------------
   logic       soData_q;
   logic       soEn_q;
   logic [6:0] txShift_q;
   logic       talking;
   logic [7:0] outByte;

   assign talking = (state_q == scd_pkg::ST_READ) || (state_q == scd_pkg::ST_STATUS);
   assign outByte = (state_q == scd_pkg::ST_READ) ? regRdData : statByte_q;

   // Each byte is fetched at its first falling edge, after the pointer settled
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         soData_q  <= 1'b0;
         soEn_q    <= 1'b0;
         txShift_q <= 7'h00;
      end
      else
      begin
         soEn_q <= csLow && talking;
         if (!csLow)
         begin
            soData_q <= 1'b0;
         end
         else if (sckFall && talking)
         begin
            if (bitCnt_q == `SCD_FIRST_BIT)
            begin
               soData_q  <= outByte[7];
               txShift_q <= outByte[6:0];
            end
            else
            begin
               soData_q  <= txShift_q[6];
               txShift_q <= {txShift_q[5:0], 1'b0};
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Output assignments
   // ------------------------------------------------------------
   assign soOut        = soData_q;
   assign soOe         = soEn_q;
   assign regAddr      = addr_q;
   assign regWrEn      = wrEn_q;
   assign regWrData    = wrData_q;
   assign regWrMask    = wrMask_q;
   assign softResetReq = softRst_q;
   assign txReqSet     = tx_request_bit_q;
   assign rxFlagClr    = rxClr_q;

endmodule : scd_spi_decoder

// [verilog/scd_sync.sv]
`timescale 1ns/1ns
module scd_sync
#(
   parameter int                 WIDTH     = 3,
   parameter int                 STAGES    = 2,
   parameter logic [WIDTH-1:0]   RESET_VAL = '0
)
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rst_b,
   // Pins in, synchronised levels out
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   if (STAGES < 2 || WIDTH < 1)
   begin : gBadParam
      $error("scd_sync needs at least two stages and one bit");
   end

   // ------------------------------------------------------------
   // Flop chain
   // ------------------------------------------------------------
   logic [WIDTH-1:0] stage_q [STAGES];

   // First stage feeds only the next stage, never any logic
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         for (int i = 0; i < STAGES; i++)
         begin
            stage_q[i] <= RESET_VAL;
         end
      end
      else
      begin
         stage_q[0] <= asyncIn;
         for (int i = 1; i < STAGES; i++)
         begin
            stage_q[i] <= stage_q[i-1];
         end
      end
   end

   assign syncOut = stage_q[STAGES-1];

endmodule : scd_sync
